//--- design/dual_adc_ctrl.sv
// Purpose: Conversion control for two 16-bit SAR converters, single-ended or differential
// Assumes: Timer overflows are one-cycle pulses on sys_clk; start pins are asynchronous
// Notes:   Registers over APB; pready comes one cycle into the access phase
`timescale 1ns/1ps
`include "dual_adc_defines.svh"

// Functional notes
// - A converter runs only while its enable bit is 1, else shut down.
// - Differential: second converter follows first's settings except during calibration.
// - Single-ended: both converters configured independently, simultaneous or different speeds.
// - Each converter has separate bias generator and reference buffer enables.
// - Conversion clock is system clock divided by divider field plus one.
// - First converter starts from busy write, Timer 3, pin edge, Timer 2.
// - Second adds a fifth source: write of 1 to first's busy bit.
// - Busy reads 1 throughout a conversion and 0 after completion.
// - Busy falling edge at completion sets done flag at control bit 5, pulses interrupt; a disable abort does neither.
// - Results per converter; differential result only in first's result registers.
// - Enabled and idle converter tracks its input continuously.
// - Track mode 1 inserts a tracking period after the start event.
// - With pin start in track mode 0, tracking lasts until the pin's rising edge.
// - Track mode 0 conversion time follows table, 21 to 300 clocks.
// - Track mode 1 conversion time follows table, 38 to 556 clocks.
// - Channel select bit 6 picks single-ended (0) or differential (1).
module dual_adc_ctrl
	import dual_adc_pkg::*;
(
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 sys_rst,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [`ADDR_W-1:0]   paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Start sources and calibration status
	input  wire timer_evt_t           timer_evt,
	input  wire logic [1:0]           ext_start_pin,
	input  wire logic                 calib_active,
	// Analog front end data
	input  wire logic [15:0]          sample0_data,
	input  wire logic [15:0]          sample1_data,
	input  wire logic [15:0]          sample_diff_data,
	// Analog control
	output logic      [1:0]           converter_enable,
	output logic      [1:0]           bias_generator_enable,
	output logic      [1:0]           reference_buffer_enable,
	output logic                      differential_select,
	output logic      [1:0]           track_hold,
	output logic      [1:0]           conv_clk_tick,
	output logic      [1:0]           conv_busy,
	output logic      [1:0]           conv_done_pulse
);

	conv_cfg_t      cfg_reg       [2];
	conv_cfg_t      eff_cfg       [2];
	logic [1:0]     conv_done_flag;
	logic [15:0]    result_reg    [2];
	conv_state_t    state_reg     [2];
	logic [9:0]     cnt_reg       [2];
	logic [3:0]     div_cnt_reg   [2];
	logic [1:0]     sync1_reg;
	logic [1:0]     sync2_reg;
	logic [1:0]     sync3_reg;
	logic [1:0]     pin_level_reg;
	logic [1:0]     pin_rise;
	logic [1:0]     sw_start;
	logic [1:0]     start_evt;
	logic [1:0]     finish;
	logic           slave_mode;
	logic           wr_en;
	logic           rd_en;
	logic [7:0]     rd_byte;
	logic           rd_hit;

	// Reset images, kept as constants so the reset branch stays constant-only
	localparam logic [7:0] ctl_reset_val   = `CTL_RESET;
	localparam logic [7:0] cfg_reset_val   = `CFG_RESET;
	localparam logic [7:0] chsel_reset_val = `CHSEL_RESET;

	// Control register offset of converter idx
	function automatic logic [`ADDR_W-1:0] ctl_offset(input int unsigned idx);
		ctl_offset = (idx == 0) ? `OFS_CTL0 : `OFS_CTL1;
	endfunction

	// Control byte image; the first converter's mode bit 2 never leaves 0
	function automatic logic [7:0] ctl_read_byte(input conv_cfg_t cfg, input logic done,
		input logic busy);
		ctl_read_byte = {cfg.enable, cfg.track_mode, done, busy, 1'b0, cfg.start_mode};
	endfunction

	// Tracking length falls out as the difference of the two tables
	function automatic logic [9:0] conv_cycles(input logic [3:0] div, input logic tm);
		logic [159:0] tab;
		tab = tm ? `CONV_TAB_TM1 : `CONV_TAB_TM0;
		conv_cycles = tab[div*10 +: 10];
	endfunction

	// Codes 5 to 7 select no source, so such a converter starts only while slaved in differential mode
	function automatic logic pick_start(input logic [2:0] mode, input logic own_sw,
		input logic pin, input logic first_sw, input logic allow_fifth);
		case (mode)
			3'h0:    pick_start = own_sw;
			3'h1:    pick_start = timer_evt.timer3_overflow;
			3'h2:    pick_start = pin;
			3'h3:    pick_start = timer_evt.timer2_overflow;
			3'h4:    pick_start = allow_fifth & first_sw;
			default: pick_start = 1'b0;
		endcase
	endfunction

	// APB handshake: writes act at the edge where pready is sampled high; reads load prdata one edge earlier, as pready rises
	assign wr_en = psel & penable & pready & pwrite;
	assign rd_en = psel & penable & ~pready;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= rd_en;
			pslverr <= rd_en & ~rd_hit;
		end
	end

	// Read data holds between reads so a slow master still sees it
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en && !pwrite) begin
			prdata <= {24'h00_0000, rd_byte};
		end
	end

	always_comb begin
		rd_hit  = 1'b1;
		rd_byte = 8'h00;
		case (paddr)
			`OFS_CTL0:    rd_byte = ctl_read_byte(cfg_reg[0], conv_done_flag[0], conv_busy[0]);
			`OFS_CTL1:    rd_byte = ctl_read_byte(cfg_reg[1], conv_done_flag[1], conv_busy[1]);
			`OFS_CFG0:    rd_byte = {cfg_reg[0].divider, 4'h0};
			`OFS_CFG1:    rd_byte = {cfg_reg[1].divider, 4'h0};
			`OFS_REF0:    rd_byte = {6'h00, reference_buffer_enable[0], bias_generator_enable[0]};
			`OFS_REF1:    rd_byte = {6'h00, reference_buffer_enable[1], bias_generator_enable[1]};
			`OFS_CHSEL:   rd_byte = {1'b0, differential_select, 6'h00};
			`OFS_RES0_HI: rd_byte = result_reg[0][15:8];
			`OFS_RES0_LO: rd_byte = result_reg[0][7:0];
			`OFS_RES1_HI: rd_byte = result_reg[1][15:8];
			`OFS_RES1_LO: rd_byte = result_reg[1][7:0];
			default:      rd_hit  = 1'b0;
		endcase
	end

	// Configuration registers
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int n = 0; n < 2; n++) begin
				cfg_reg[n] <= conv_cfg_t'({ctl_reset_val[7:6], cfg_reset_val[7:4], 3'h0});
			end
			bias_generator_enable   <= 2'h0;
			reference_buffer_enable <= 2'h0;
			differential_select     <= chsel_reset_val[`CHSEL_DIFF_BIT];
		end else if (wr_en) begin
			case (paddr)
				`OFS_CTL0: begin
					cfg_reg[0].enable     <= pwdata[`CTL_EN_BIT];
					cfg_reg[0].track_mode <= pwdata[`CTL_TM_BIT];
					cfg_reg[0].start_mode <= {1'b0, pwdata[`CTL_MODE_LSB +: 2]};
				end
				`OFS_CTL1: begin
					cfg_reg[1].enable     <= pwdata[`CTL_EN_BIT];
					cfg_reg[1].track_mode <= pwdata[`CTL_TM_BIT];
					cfg_reg[1].start_mode <= pwdata[`CTL_MODE_LSB +: 3];
				end
				`OFS_CFG0:  cfg_reg[0].divider <= pwdata[`CFG_DIV_LSB +: 4];
				`OFS_CFG1:  cfg_reg[1].divider <= pwdata[`CFG_DIV_LSB +: 4];
				`OFS_REF0: begin
					bias_generator_enable[0]   <= pwdata[`REF_BIAS_BIT];
					reference_buffer_enable[0] <= pwdata[`REF_BUF_BIT];
				end
				`OFS_REF1: begin
					bias_generator_enable[1]   <= pwdata[`REF_BIAS_BIT];
					reference_buffer_enable[1] <= pwdata[`REF_BUF_BIT];
				end
				`OFS_CHSEL: differential_select <= pwdata[`CHSEL_DIFF_BIT];
				default: begin
				end
			endcase
		end
	end

	// Start pin synchronisers; second and third stages must agree before a change counts
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_reg     <= 2'h0;
			sync2_reg     <= 2'h0;
			sync3_reg     <= 2'h0;
			pin_level_reg <= 2'h0;
		end else begin
			sync1_reg <= ext_start_pin;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			for (int n = 0; n < 2; n++) begin
				if (sync2_reg[n] == sync3_reg[n]) begin
					pin_level_reg[n] <= sync3_reg[n];
				end
			end
		end
	end

	// Slave only outside calibration, so calibration keeps the second's own settings
	assign slave_mode = differential_select & ~calib_active;

	always_comb begin
		eff_cfg[0] = cfg_reg[0];
		eff_cfg[1] = slave_mode ? cfg_reg[0] : cfg_reg[1];
		for (int n = 0; n < 2; n++) begin
			pin_rise[n] = ~pin_level_reg[n] & (sync2_reg[n] == sync3_reg[n]) & sync3_reg[n];
			sw_start[n] = wr_en & pwdata[`CTL_BUSY_BIT] &
				(paddr == ctl_offset(n));
		end
		start_evt[0] = pick_start(eff_cfg[0].start_mode, sw_start[0], pin_rise[0],
			sw_start[0], 1'b0);
		start_evt[1] = slave_mode ? start_evt[0] :
			pick_start(eff_cfg[1].start_mode, sw_start[1], pin_rise[1], sw_start[0], 1'b1);
	end

	// Conversion sequencer, one per converter
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int n = 0; n < 2; n++) begin
				state_reg[n] <= CONV_IDLE;
				cnt_reg[n]   <= 10'h000;
			end
			conv_busy <= 2'h0;
		end else begin
			for (int n = 0; n < 2; n++) begin
				case (state_reg[n])
					CONV_IDLE: begin
						// Bias gating keeps a half-powered converter from reporting data
						if (start_evt[n] && eff_cfg[n].enable && bias_generator_enable[n]) begin
							cnt_reg[n]   <= conv_cycles(eff_cfg[n].divider,
								eff_cfg[n].track_mode) - 10'h001;
							state_reg[n] <= eff_cfg[n].track_mode ? CONV_TRACK : CONV_RUN;
							conv_busy[n] <= 1'b1;
						end
					end
					CONV_TRACK, CONV_RUN: begin
						if (!eff_cfg[n].enable) begin
							state_reg[n] <= CONV_IDLE;
							conv_busy[n] <= 1'b0;
						end else if (cnt_reg[n] == 10'h000) begin
							state_reg[n] <= CONV_IDLE;
							conv_busy[n] <= 1'b0;
						end else begin
							cnt_reg[n] <= cnt_reg[n] - 10'h001;
							if (cnt_reg[n] <= conv_cycles(eff_cfg[n].divider, 1'b0)) begin
								state_reg[n] <= CONV_RUN;
							end
						end
					end
					default: begin
						state_reg[n] <= CONV_IDLE;
						conv_busy[n] <= 1'b0;
					end
				endcase
			end
		end
	end

	always_comb begin
		for (int n = 0; n < 2; n++) begin
			finish[n] = (state_reg[n] != CONV_IDLE) & eff_cfg[n].enable & (cnt_reg[n] == 10'h000);
		end
	end

	// Completion pulse for the interrupt path, one cycle per finished conversion
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			conv_done_pulse <= 2'h0;
		end else begin
			conv_done_pulse <= finish;
		end
	end

	// Done flags: hardware set wins over a software clear in the same cycle
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			conv_done_flag  <= 2'h0;
		end else begin
			for (int n = 0; n < 2; n++) begin
				if (finish[n]) begin
					conv_done_flag[n] <= 1'b1;
				end else if (wr_en && paddr == ctl_offset(n)) begin
					conv_done_flag[n] <= pwdata[`CTL_DONE_BIT];
				end
			end
		end
	end

	// Result capture
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			result_reg[0] <= 16'h0000;
			result_reg[1] <= 16'h0000;
		end else begin
			if (finish[0]) begin
				result_reg[0] <= differential_select ? sample_diff_data : sample0_data;
			end
			if (finish[1] && !differential_select) begin
				result_reg[1] <= sample1_data;
			end
		end
	end

	// Analog controls and conversion clock ticks
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			converter_enable <= 2'h0;
			track_hold       <= 2'h0;
			conv_clk_tick    <= 2'h0;
			div_cnt_reg[0]   <= 4'h0;
			div_cnt_reg[1]   <= 4'h0;
		end else begin
			for (int n = 0; n < 2; n++) begin
				converter_enable[n] <= eff_cfg[n].enable;
				track_hold[n]       <= eff_cfg[n].enable & (state_reg[n] != CONV_RUN);
				if (state_reg[n] == CONV_IDLE || div_cnt_reg[n] == eff_cfg[n].divider) begin
					div_cnt_reg[n] <= 4'h0;
				end else begin
					div_cnt_reg[n] <= div_cnt_reg[n] + 4'h1;
				end
				conv_clk_tick[n] <= (state_reg[n] != CONV_IDLE) &&
					(div_cnt_reg[n] == eff_cfg[n].divider);
			end
		end
	end

endmodule // dual_adc_ctrl

//--- design/dual_adc_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts for the converter control
// Assumes: APB byte addresses, one 32-bit word per register, 8-bit register data in low bits
// Notes:   Timing tables list setting 1111 first so that setting n sits at bits [10n+9:10n]
`ifndef DUAL_ADC_DEFINES_SVH
`define DUAL_ADC_DEFINES_SVH

`define ADDR_W          8
`define OFS_CTL0        8'h00
`define OFS_CTL1        8'h04
`define OFS_CFG0        8'h08
`define OFS_CFG1        8'h0C
`define OFS_REF0        8'h10
`define OFS_REF1        8'h14
`define OFS_CHSEL       8'h18
`define OFS_RES0_HI     8'h1C
`define OFS_RES0_LO     8'h20
`define OFS_RES1_HI     8'h24
`define OFS_RES1_LO     8'h28

`define CTL_EN_BIT      7
`define CTL_TM_BIT      6
`define CTL_DONE_BIT    5
`define CTL_BUSY_BIT    4
`define CTL_MODE_LSB    0
`define CFG_DIV_LSB     4
`define REF_BIAS_BIT    0
`define REF_BUF_BIT     1
`define CHSEL_DIFF_BIT  6

`define CTL_RESET       8'h00
`define CFG_RESET       8'hF0
`define REF_RESET       8'h00
`define CHSEL_RESET     8'h00

`define CONV_TAB_TM0 {10'h12C, 10'h11A, 10'h107, 10'h0F5, 10'h0E2, 10'h0D0, 10'h0BD, 10'h0AB, \
	10'h098, 10'h086, 10'h073, 10'h061, 10'h04E, 10'h03A, 10'h028, 10'h015}
`define CONV_TAB_TM1 {10'h22C, 10'h20A, 10'h1E7, 10'h1C5, 10'h1A2, 10'h180, 10'h15D, 10'h13B, \
	10'h118, 10'h0F6, 10'h0D3, 10'h0B1, 10'h08E, 10'h06A, 10'h048, 10'h026}

`endif

//--- design/dual_adc_pkg.sv
// Purpose: Types shared by the converter control
// Assumes: Two converters, index 0 is the first, index 1 the second
// Notes:   Constants live in dual_adc_defines.svh
package dual_adc_pkg;

	typedef enum logic [1:0] {
		CONV_IDLE,
		CONV_TRACK,
		CONV_RUN
	} conv_state_t;

	typedef struct packed {
		logic       enable;
		logic       track_mode;
		logic [3:0] divider;
		logic [2:0] start_mode;
	} conv_cfg_t;

	typedef struct packed {
		logic timer2_overflow;
		logic timer3_overflow;
	} timer_evt_t;

endpackage

//--- sim/adc_front_model.sv
// Purpose: Far side model: timer overflows and analog samples
// Assumes: Bench asks for a timer pulse one cycle at a time
// Notes:   Samples step while idle so a stale load shows
`timescale 1ns/1ps
module adc_front_model
	import dual_adc_pkg::*;
(
	// Clock and requests
	input  wire logic [1:0]  fire_tmr,
	input  wire logic        sys_clk,
	input  wire logic [1:0]  conv_busy,
	// Toward the block
	output timer_evt_t       timer_evt,
	output logic      [15:0] sample0_data,
	output logic      [15:0] sample1_data,
	output logic      [15:0] sample_diff_data
);
	initial begin
		timer_evt = '0;
		sample0_data = 16'h1234;
		sample1_data = 16'hA5C3;
		sample_diff_data = 16'h8E71;
	end
	always @(posedge sys_clk) begin
		timer_evt <= timer_evt_t'(fire_tmr);
		if (!conv_busy[0]) begin
			sample0_data <= sample0_data + 16'h1357;
			sample_diff_data <= sample_diff_data - 16'h0B3D;
		end
		if (!conv_busy[1])
			sample1_data <= sample1_data + 16'h2E9B;
	end
endmodule // adc_front_model

//--- sim/dual_adc_ctrl_assertions.sv
// Purpose: Port checks for the converter control
// Assumes: pready in the second access cycle; busy lasts the table time
// Notes:   Each converter check watches one converter; both share the logic
`timescale 1ns/1ps
module dual_adc_ctrl_assertions (
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [1:0]  converter_enable,
	input wire logic [1:0]  track_hold,
	input wire logic [1:0]  conv_busy,
	input wire logic [1:0]  conv_done_pulse
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	chk_ready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_done_on_fall: assert property (conv_done_pulse[0] |-> $fell(conv_busy[0]))
		else $error("done pulse without busy fall");
	chk_done_single: assert property (conv_done_pulse[1] |=> !conv_done_pulse[1])
		else $error("done pulse too long");
	chk_busy_min_len: assert property ($rose(conv_busy[0]) |->
		(conv_busy[0] || !converter_enable[0])[*8])
		else $error("conversion too short");
	chk_off_stays_idle: assert property ($rose(conv_busy[1]) |-> converter_enable[1])
		else $error("disabled converter started");
	chk_track_idle: assert property (converter_enable[0] && $past(converter_enable[0])
		&& !conv_busy[0] && !$past(conv_busy[0]) |-> track_hold[0])
		else $error("idle converter not tracking");
	cover property ($fell(conv_busy[0]));
	cover property (conv_busy == 2'b11);
	cover property (pslverr);
endmodule // dual_adc_ctrl_assertions

bind dual_adc_ctrl dual_adc_ctrl_assertions u_dual_adc_ctrl_assertions (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.converter_enable(converter_enable), .track_hold(track_hold),
	.conv_busy(conv_busy), .conv_done_pulse(conv_done_pulse));

//--- sim/tb_top.sv
// Purpose: Self-checking bench for the converter control
// Assumes: APB answer and conversion timing as handed over
// Notes:   Start sources swept in one loop with random divider and track mode
`timescale 1ns/1ps
`include "dual_adc_defines.svh"
module tb_top;
	import dual_adc_pkg::*;
	logic        sys_clk, sys_rst, psel, penable, pwrite, calib_active, pready, pslverr;
	logic        differential_select, err;
	logic [7:0]  paddr, cv;
	logic [31:0] pwdata, prdata, rd, r1;
	logic [1:0]  ext_start_pin, fire_tmr, converter_enable, bias_generator_enable;
	logic [1:0]  reference_buffer_enable, track_hold, conv_clk_tick, conv_busy, conv_done_pulse;
	timer_evt_t  timer_evt;
	logic [15:0] sample0_data, sample1_data, sample_diff_data, smp;
	int          n_fail, n_tests, cyc, n, nt, tm, dv, md, c;
	int t0[16] = '{21,40,58,78,97,115,134,152,171,189,208,226,245,263,282,300};
	int t1[16] = '{38,72,106,142,177,211,246,280,315,349,384,418,453,487,522,556};

	dual_adc_ctrl u_dual_adc_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_evt(timer_evt),
		.ext_start_pin(ext_start_pin), .calib_active(calib_active),
		.sample0_data(sample0_data), .sample1_data(sample1_data),
		.sample_diff_data(sample_diff_data), .converter_enable(converter_enable),
		.bias_generator_enable(bias_generator_enable), .track_hold(track_hold),
		.reference_buffer_enable(reference_buffer_enable), .conv_busy(conv_busy),
		.differential_select(differential_select), .conv_clk_tick(conv_clk_tick),
		.conv_done_pulse(conv_done_pulse));
	adc_front_model u_adc_front_model (.fire_tmr(fire_tmr), .sys_clk(sys_clk),
		.conv_busy(conv_busy), .timer_evt(timer_evt), .sample0_data(sample0_data),
		.sample1_data(sample1_data), .sample_diff_data(sample_diff_data));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Long conversions at divider 1111 set the ceiling
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			report_and_stop();
		end
	end

	task report_and_stop;
		if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task fire(input int c, input int m);
		case (m)
			0: apb(1'b1, c ? `OFS_CTL1 : `OFS_CTL0, cv | 8'h10);
			1, 3: begin
				fire_tmr <= (m == 1) ? 2'b01 : 2'b10;
				@(posedge sys_clk);
				fire_tmr <= 2'b00;
			end
			2: begin
				ext_start_pin[c] <= 1'b1;
				repeat (8) @(posedge sys_clk);
				ext_start_pin[c] <= 1'b0;
			end
			default: apb(1'b1, `OFS_CTL0, 8'h90);
		endcase
	endtask
	task measure(input int c, input int tm, input int dv);
		n = 0;
		while (conv_busy[c] !== 1'b1 && n < 40) begin
			n++;
			@(posedge sys_clk);
		end
		n = 0;
		nt = 0;
		while (conv_busy[c] === 1'b1) begin
			n++;
			if (n == 5) chk(32'(track_hold[c]), 32'(tm));
			@(posedge sys_clk);
			nt += conv_clk_tick[c];
		end
		smp = c ? sample1_data : sample0_data;
		chk(n, tm ? t1[dv] : t0[dv]);
		chk(nt, (tm ? t1[dv] : t0[dv]) / (dv + 1));
	endtask
	task results(input int c);
		apb(1'b0, c ? `OFS_RES1_HI : `OFS_RES0_HI, 8'h0);
		chk(rd, 32'(smp[15:8]));
		apb(1'b0, c ? `OFS_RES1_LO : `OFS_RES0_LO, 8'h0);
		chk(rd, 32'(smp[7:0]));
	endtask

	initial begin
		sys_rst = 1'b1;
		{psel, penable, pwrite, calib_active} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ext_start_pin = 2'b00;
		fire_tmr = 2'b00;
		{n_fail, n_tests, cyc} = '0;
		void'($urandom(5));
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		apb(1'b0, `OFS_CFG1, 8'h0);
		chk(rd, 32'hF0);
		apb(1'b0, 8'h2C, 8'h0);
		chk({rd[30:0], err}, 32'h1);
		apb(1'b1, `OFS_REF0, 8'h03);
		apb(1'b1, `OFS_REF1, 8'h01);
		chk(32'({bias_generator_enable, reference_buffer_enable}), 32'hD);
		for (int i = 0; i < 24; i++) begin
			c = i % 2;
			md = (i / 2) % (c ? 5 : 4);
			tm = $urandom_range(1, 0);
			dv = $urandom_range(15, 0);
			cv = 8'h80 | 8'(tm << 6) | 8'(md);
			if (md == 4) apb(1'b1, `OFS_CTL0, 8'h80);
			apb(1'b1, c ? `OFS_CFG1 : `OFS_CFG0, 8'(dv << 4));
			apb(1'b1, c ? `OFS_CTL1 : `OFS_CTL0, cv);
			fork
				measure(c, tm, dv);
				begin
					fire(c, md);
					repeat (4) @(posedge sys_clk);
					fire(c, md);
				end
			join
			while (conv_busy !== 2'b00) @(posedge sys_clk);
			apb(1'b0, c ? `OFS_CTL1 : `OFS_CTL0, 8'h0);
			chk(32'(rd[5]), 32'h1);
			results(c);
		end
		apb(1'b1, `OFS_CTL1, 8'h00);
		apb(1'b0, `OFS_RES1_HI, 8'h0);
		r1 = rd;
		apb(1'b1, `OFS_CHSEL, 8'h40);
		apb(1'b1, `OFS_CFG0, 8'h20);
		apb(1'b1, `OFS_CTL0, 8'h80);
		chk(32'({differential_select, converter_enable}), 32'h7);
		calib_active <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk(32'(converter_enable), 32'h1);
		calib_active <= 1'b0;
		repeat (3) @(posedge sys_clk);
		fork
			measure(0, 0, 2);
			apb(1'b1, `OFS_CTL0, 8'h90);
			begin
				repeat (8) @(posedge sys_clk);
				chk(32'(conv_busy), 32'h3);
			end
		join
		smp = sample_diff_data;
		while (conv_busy !== 2'b00) @(posedge sys_clk);
		results(0);
		apb(1'b0, `OFS_RES1_HI, 8'h0);
		chk(rd, r1);
		apb(1'b1, `OFS_CHSEL, 8'h00);
		apb(1'b1, `OFS_CTL0, 8'h00);
		// Enable output is registered one cycle behind the write
		@(posedge sys_clk);
		chk(32'(converter_enable[0]), 32'h0);
		apb(1'b1, `OFS_CTL0, 8'h10);
		repeat (10) @(posedge sys_clk);
		chk(32'(conv_busy[0]), 32'h0);
		report_and_stop();
	end
endmodule // tb_top
